/* rtl/phyev_pkg.sv */
// What this block does
// (RULE_01) interface select bit 9, strap reset
// (RULE_02) far-end fault only without auto-negotiation
// (RULE_03) bit 2 enlarges reduced-interface elastic buffer
// (RULE_04) bit 1 enables out-of-band idle signalling; code enables it only while bit 9 is clear (reduced interface)
// (RULE_05) fiber flag disables negotiation and scrambling
// (RULE_06) speed bit 9, duplex bit 8
// (RULE_07) pause only after negotiation, both symmetric
// (RULE_08) bit 6 latches negotiation complete
// (RULE_09) bit 5 latches remote fault
// (RULE_10) bit 4 latches link failure
// (RULE_11) bit 3 latches code word acknowledge
// (RULE_12) bit 2 latches parallel detection fault
// (RULE_13) bit 1 latches page received
// (RULE_14) bit 0 latches 64k errors, read clears counter
// (RULE_15) global enable bit 7, reset 0
// (RULE_16) bit 8 selects pin direction, reset 1
// (RULE_17) event bits clear on read and reset
// (RULE_18) interrupt pin follows pending enabled events
// (RULE_19) reserved fields read defaults, ignore writes
package phyev_pkg;
	// register addresses on the management port
	localparam logic [4:0] REG_MAC_IF_CFG = 5'h10;
	localparam logic [4:0] REG_EVT_STATUS = 5'h11;
	localparam logic [4:0] REG_EVT_ENABLE = 5'h12;
	// interface config fields
	localparam int CFG_MII_SEL = 9;
	localparam int CFG_FEF_EN = 5;
	localparam int CFG_FIFO_EXT = 2;
	localparam int CFG_RMII_OOB = 1;
	localparam logic [15:0] CFG_RST = 16'h1000;
	localparam logic [15:0] CFG_WR_MASK = 16'h27E7;
	// status fields
	localparam int STS_FIBER = 10;
	localparam int STS_SPEED = 9;
	localparam int STS_DUPLEX = 8;
	localparam int STS_PAUSE = 7;
	localparam int EV_AN_DONE = 6;
	localparam int EV_REM_FLT = 5;
	localparam int EV_LINK_FAIL = 4;
	localparam int EV_ACK_MATCH = 3;
	localparam int EV_PD_FAULT = 2;
	localparam int EV_PAGE_RX = 1;
	localparam int EV_RX_FULL = 0;
	localparam int NUM_EV = 7;
	// enable register fields
	localparam int ENA_PIN_IN = 8;
	localparam int ENA_GLOBAL = 7;
	localparam logic [15:0] ENA_RST = 16'h0100;
	localparam logic [15:0] ENA_WR_MASK = 16'h01FF;
	// management frame framing
	localparam logic [5:0] PRE_ONES = 6'h20;
	localparam logic [4:0] HDR_LAST = 5'h0D;
	localparam logic [4:0] TA_LAST = 5'h01;
	localparam logic [4:0] DATA_LAST = 5'h0F;
	localparam logic [1:0] OP_WRITE = 2'b01;
	localparam logic [1:0] OP_READ = 2'b10;
	localparam logic [1:0] START_CODE = 2'b01;
	// receive error limit, 64k packets
	localparam int ERR_LIMIT = 65536;
	typedef enum logic [1:0] {
		ST_PRE = 2'b00,
		ST_HDR = 2'b01,
		ST_TA = 2'b11,
		ST_DATA = 2'b10
	} phyev_st_t;
endpackage

/* rtl/phyev_sync.sv */
`timescale 1ns/10ps
`default_nettype none
module phyev_sync #(
	parameter int W = 1
) (
	input wire logic i_clk, // sampling clock
	input wire logic [W-1:0] i_d, // asynchronous inputs
	output logic [W-1:0] o_q // synchronised outputs
);
	logic [W-1:0] meta_q;
	// two-stage chain; first stage feeds only the second
	always_ff @(posedge i_clk) begin
		meta_q <= i_d;
		o_q <= meta_q;
	end
endmodule
`default_nettype wire

/* rtl/phyev_err_cnt.sv */
`timescale 1ns/10ps
`default_nettype none
module phyev_err_cnt
	import phyev_pkg::*;
#(
	parameter int LIMIT = ERR_LIMIT,
	parameter int CW = $clog2(LIMIT + 1)
) (
	input wire logic i_clk, // clock
	input wire logic i_rst, // sync reset
	input wire logic i_err, // one errored packet
	input wire logic i_clr, // clear by status read
	output logic o_full // pulse on reaching limit
);
	logic [CW-1:0] cnt_q;
	localparam logic [CW-1:0] TOP = CW'(LIMIT);
	// saturates so that full fires once per fill
	always_ff @(posedge i_clk) begin
		if (i_rst || i_clr) begin
			cnt_q <= '0;
		end else if (i_err && cnt_q != TOP) begin
			cnt_q <= cnt_q + 1'b1;
		end
	end
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_full <= 1'b0;
		end else begin
			o_full <= !i_clr && i_err && (cnt_q == TOP - 1'b1);
		end
	end
endmodule
`default_nettype wire

/* rtl/phyev_top.sv */
`timescale 1ns/10ps
`default_nettype none
module phyev_top
	import phyev_pkg::*;
#(
	parameter logic [4:0] PHY_ADDR = 5'h01,
	parameter int ERR_MAX = ERR_LIMIT
) (
	input wire logic I_CLK, // 25 MHz clock
	input wire logic I_RST, // sync reset, high
	input wire logic I_MDC, // management clock pin
	input wire logic I_MDIO, // management data in
	output logic O_MDIO, // management data out
	output logic O_MDIO_OE, // management data drive
	input wire logic I_PWRDN_IRQ_PIN, // shared pin level
	output logic O_PWRDN_IRQ_PIN, // shared pin out, irq low
	output logic O_PWRDN_IRQ_OE, // shared pin drive
	output logic O_POWER_DOWN, // power-down request
	input wire logic I_MII_STRAP, // interface strap pin
	input wire logic I_FIBER_SEL, // fiber select pin
	input wire logic I_AN_ENABLE, // negotiation enabled
	input wire logic I_AN_DONE, // negotiation complete
	input wire logic I_LOCAL_PAUSE, // local symmetric pause
	input wire logic I_PARTNER_PAUSE, // partner symmetric pause
	input wire logic I_LINK_UP, // link established
	input wire logic I_SPEED_100, // 100 Mb/s resolved
	input wire logic I_FULL_DUPLEX, // full duplex resolved
	input wire logic I_REMOTE_FAULT, // remote fault seen
	input wire logic I_ACK_MATCH, // code word ack match
	input wire logic I_PD_FAULT, // parallel detect fault
	input wire logic I_PAGE_RX, // page received
	input wire logic I_RX_ERR, // errored packet pulse
	output logic O_MII_SEL, // full interface selected
	output logic O_FEF_ACTIVE, // far-end fault active
	output logic O_FIFO_EXT, // extended elastic buffer
	output logic O_RMII_OOB, // out-of-band signalling
	output logic O_AN_ALLOWED, // negotiation allowed
	output logic O_SCRAMBLE_EN // scrambler enabled
);
	logic mdc_s, mdio_s, pin_s, strap_s, fiber_s;
	logic mdc_prev_q, rise;
	phyev_st_t st_q;
	logic [5:0] ones_q;
	logic [4:0] cnt_q;
	logic [12:0] sr_q;
	logic [13:0] hdr_w;
	logic [15:0] wsr_q, wr_w, rsr_q;
	logic [4:0] addr_q;
	logic rd_q, hit_q;
	logic hdr_done, rd_clr, wr_go;
	logic [15:0] cfg_q, ena_q, stat_w;
	logic [NUM_EV-1:0] flags_q, ev_set;
	logic an_prev_q, link_prev_q, err_full, irq_q;
	logic strap_ld_q;

	// pins from outside the clock domain
	phyev_sync #(.W(5)) u_sync (
		.i_clk(I_CLK),
		.i_d({I_MDC, I_MDIO, I_PWRDN_IRQ_PIN, I_MII_STRAP, I_FIBER_SEL}),
		.o_q({mdc_s, mdio_s, pin_s, strap_s, fiber_s})
	);

	phyev_err_cnt #(.LIMIT(ERR_MAX)) u_err (
		.i_clk(I_CLK),
		.i_rst(I_RST),
		.i_err(I_RX_ERR),
		.i_clr(rd_clr),
		.o_full(err_full)
	);

	// register read view
	function automatic logic [15:0] rd_mux(input logic [4:0] a, input logic [15:0] c, input logic [15:0] s,
		input logic [15:0] e);
		case (a)
			REG_MAC_IF_CFG: rd_mux = c;
			REG_EVT_STATUS: rd_mux = s;
			REG_EVT_ENABLE: rd_mux = e;
			default: rd_mux = 16'h0000;
		endcase
	endfunction

	// management clock edge, seen on the synchronised copy
	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			mdc_prev_q <= 1'b0;
		end else begin
			mdc_prev_q <= mdc_s;
		end
	end
	assign rise = mdc_s && !mdc_prev_q;
	assign hdr_w = {sr_q, mdio_s};
	assign wr_w = {wsr_q[14:0], mdio_s};
	assign hdr_done = rise && st_q == ST_HDR && cnt_q == HDR_LAST;
	assign rd_clr = hdr_done && hdr_w[13:12] == START_CODE && hdr_w[11:10] == OP_READ
		&& hdr_w[9:5] == PHY_ADDR && hdr_w[4:0] == REG_EVT_STATUS;
	assign wr_go = rise && st_q == ST_DATA && cnt_q == DATA_LAST && hit_q && !rd_q;

	// frame sequencer: preamble, header, turnaround, data
	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			st_q <= ST_PRE;
			ones_q <= 6'h00;
			cnt_q <= 5'h00;
			sr_q <= 13'h0000;
			wsr_q <= 16'h0000;
			addr_q <= 5'h00;
			rd_q <= 1'b0;
			hit_q <= 1'b0;
		end else if (rise) begin
			case (st_q)
				ST_PRE: begin
					if (mdio_s) begin
						ones_q <= (ones_q == PRE_ONES) ? ones_q : ones_q + 1'b1;
					end else if (ones_q == PRE_ONES) begin
						st_q <= ST_HDR;
						cnt_q <= 5'h01;
						sr_q <= 13'h0000;
					end else begin
						ones_q <= 6'h00;
					end
				end
				ST_HDR: begin
					sr_q <= hdr_w[12:0];
					cnt_q <= cnt_q + 1'b1;
					if (cnt_q == HDR_LAST) begin
						st_q <= ST_TA;
						cnt_q <= 5'h00;
						addr_q <= hdr_w[4:0];
						rd_q <= hdr_w[11:10] == OP_READ;
						hit_q <= hdr_w[13:12] == START_CODE && hdr_w[9:5] == PHY_ADDR
							&& (hdr_w[11:10] == OP_READ || hdr_w[11:10] == OP_WRITE);
					end
				end
				ST_TA: begin
					cnt_q <= cnt_q + 1'b1;
					if (cnt_q == TA_LAST) begin
						st_q <= ST_DATA;
						cnt_q <= 5'h00;
					end
				end
				ST_DATA: begin
					wsr_q <= wr_w;
					cnt_q <= cnt_q + 1'b1;
					if (cnt_q == DATA_LAST) begin
						st_q <= ST_PRE;
						ones_q <= 6'h00;
					end
				end
				default: st_q <= ST_PRE;
			endcase
		end
	end

	// read driver: drive zero in second turnaround bit, then msb first
	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			rsr_q <= 16'h0000;
			O_MDIO <= 1'b0;
			O_MDIO_OE <= 1'b0;
		end else if (rise) begin
			if (hdr_done) begin
				rsr_q <= rd_mux(hdr_w[4:0], cfg_q, stat_w, ena_q);
			end else if (st_q == ST_TA && hit_q && rd_q) begin
				O_MDIO_OE <= 1'b1;
				if (cnt_q == TA_LAST) begin
					O_MDIO <= rsr_q[15];
					rsr_q <= {rsr_q[14:0], 1'b0};
				end else begin
					O_MDIO <= 1'b0;
				end
			end else if (st_q == ST_DATA && O_MDIO_OE) begin
				O_MDIO <= rsr_q[15];
				rsr_q <= {rsr_q[14:0], 1'b0};
				if (cnt_q == DATA_LAST) begin
					O_MDIO_OE <= 1'b0;
				end
			end
		end
	end

	// one more strap load just after release; a short reset may end before the sync chain fills
	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			strap_ld_q <= 1'b1;
		end else begin
			strap_ld_q <= 1'b0;
		end
	end

	// interface config; strap captured while reset is held
	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			cfg_q <= CFG_RST;
			cfg_q[CFG_MII_SEL] <= strap_s; // RULE_01
		end else if (strap_ld_q) begin
			cfg_q[CFG_MII_SEL] <= strap_s; // RULE_01
		end else if (wr_go && addr_q == REG_MAC_IF_CFG) begin
			cfg_q <= (wr_w & CFG_WR_MASK) | (CFG_RST & ~CFG_WR_MASK); // RULE_19
		end
	end

	// event enables and pin direction
	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			ena_q <= ENA_RST; // RULE_15 RULE_16
		end else if (wr_go && addr_q == REG_EVT_ENABLE) begin
			ena_q <= wr_w & ENA_WR_MASK; // RULE_19
		end
	end

	// event sources, edges found against the previous level
	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			an_prev_q <= 1'b0;
			link_prev_q <= 1'b0;
		end else begin
			an_prev_q <= I_AN_DONE;
			link_prev_q <= I_LINK_UP;
		end
	end
	always_comb begin
		ev_set = '0;
		ev_set[EV_AN_DONE] = I_AN_DONE && !an_prev_q; // RULE_08
		ev_set[EV_REM_FLT] = I_REMOTE_FAULT; // RULE_09
		ev_set[EV_LINK_FAIL] = link_prev_q && !I_LINK_UP; // RULE_10
		ev_set[EV_ACK_MATCH] = I_ACK_MATCH; // RULE_11
		ev_set[EV_PD_FAULT] = I_PD_FAULT; // RULE_12
		ev_set[EV_PAGE_RX] = I_PAGE_RX; // RULE_13
		ev_set[EV_RX_FULL] = err_full; // RULE_14
	end

	// latch-high flags; a new event beats the read clear
	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			flags_q <= '0; // RULE_17
		end else begin
			flags_q <= (rd_clr ? '0 : flags_q) | ev_set; // RULE_17
		end
	end

	// status view; speed and duplex only mean much with link up
	always_comb begin
		stat_w = 16'h0000; // RULE_19
		stat_w[STS_FIBER] = fiber_s; // RULE_05
		stat_w[STS_SPEED] = I_SPEED_100; // RULE_06
		stat_w[STS_DUPLEX] = I_FULL_DUPLEX; // RULE_06
		stat_w[STS_PAUSE] = I_AN_DONE && I_LOCAL_PAUSE && I_PARTNER_PAUSE; // RULE_07
		stat_w[NUM_EV-1:0] = flags_q;
	end

	// interrupt request, registered to keep the pin glitch free
	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= !ena_q[ENA_PIN_IN] && ena_q[ENA_GLOBAL] && |(flags_q & ena_q[NUM_EV-1:0]); // RULE_15 RULE_18
		end
	end
	assign O_PWRDN_IRQ_OE = !ena_q[ENA_PIN_IN]; // RULE_16
	assign O_PWRDN_IRQ_PIN = !irq_q; // RULE_18

	// configuration outputs to the datapath
	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			O_MII_SEL <= 1'b0;
			O_FEF_ACTIVE <= 1'b0;
			O_FIFO_EXT <= 1'b0;
			O_RMII_OOB <= 1'b0;
			O_AN_ALLOWED <= 1'b0;
			O_SCRAMBLE_EN <= 1'b0;
			O_POWER_DOWN <= 1'b0;
		end else begin
			O_MII_SEL <= cfg_q[CFG_MII_SEL]; // RULE_01
			O_FEF_ACTIVE <= cfg_q[CFG_FEF_EN] && !I_AN_ENABLE; // RULE_02
			O_FIFO_EXT <= cfg_q[CFG_FIFO_EXT]; // RULE_03
			O_RMII_OOB <= cfg_q[CFG_RMII_OOB] && !cfg_q[CFG_MII_SEL]; // RULE_04
			O_AN_ALLOWED <= I_AN_ENABLE && !fiber_s; // RULE_05
			O_SCRAMBLE_EN <= !fiber_s; // RULE_05
			O_POWER_DOWN <= ena_q[ENA_PIN_IN] && pin_s; // RULE_16
		end
	end

	default clocking @(posedge I_CLK); endclocking
	default disable iff (I_RST);

	strap_load_a: assert property ($fell(I_RST) |=> cfg_q[CFG_MII_SEL] == $past(strap_s)) // RULE_01
		else $error("strap not loaded into interface select");
	fef_gate_a: assert property (O_FEF_ACTIVE |-> $past(cfg_q[CFG_FEF_EN]) && !$past(I_AN_ENABLE)) // RULE_02
		else $error("far-end fault active with negotiation on");
	fiber_off_a: assert property (fiber_s ##1 fiber_s |-> !O_AN_ALLOWED && !O_SCRAMBLE_EN) // RULE_05
		else $error("fiber mode left negotiation or scrambler on");
	pause_cond_a: assert property (stat_w[STS_PAUSE] |-> I_AN_DONE && I_LOCAL_PAUSE && I_PARTNER_PAUSE) // RULE_07
		else $error("pause reported without both sides");
	link_fail_a: assert property ($fell(I_LINK_UP) |=> flags_q[EV_LINK_FAIL]) // RULE_10
		else $error("link failure not latched");
	err_full_a: assert property (err_full |=> flags_q[EV_RX_FULL]) // RULE_14
		else $error("error counter full not latched");
	read_clear_a: assert property (rd_clr && ev_set == '0 |=> flags_q == '0) // RULE_17
		else $error("event flags survive status read");
	irq_drive_a: assert property (!ena_q[ENA_PIN_IN] && ena_q[ENA_GLOBAL] && |(flags_q & ena_q[NUM_EV-1:0])
		&& !(wr_go && addr_q == REG_EVT_ENABLE) |=> O_PWRDN_IRQ_OE && !O_PWRDN_IRQ_PIN) // RULE_18
		else $error("interrupt pin not asserted");
	global_off_a: assert property (!ena_q[ENA_GLOBAL] |=> O_PWRDN_IRQ_PIN) // RULE_15
		else $error("interrupt asserted while disabled");
	reserved_ro_a: assert property (cfg_q[15:14] == 2'b00 && cfg_q[12:11] == 2'b10 && ena_q[15:9] == '0) // RULE_19
		else $error("reserved field changed");
	read_frame_c: cover property (rd_clr ##[1:300] !O_MDIO_OE);
	write_frame_c: cover property (wr_go && addr_q == REG_EVT_ENABLE);
	irq_seen_c: cover property (O_PWRDN_IRQ_OE && !O_PWRDN_IRQ_PIN);
endmodule
`default_nettype wire

/* testbench/phyev_mdio_host.sv */
`timescale 1ns/10ps
`default_nettype none
// management host; mdc idles low between frames
module phyev_mdio_host
	import phyev_pkg::*;
(
	input wire logic i_clk, // bench clock
	input wire logic i_mdio, // resolved line
	output logic o_mdc, // management clock
	output logic o_mdio, // host data
	output logic o_oe // host drives line
);
	initial begin
		o_mdc = 1'b0;
		o_mdio = 1'b1;
		o_oe = 1'b0;
	end
	// data set while mdc low, line sampled at mdc rise
	task automatic bit_cyc(input logic drv, input logic v, output logic s);
		o_oe <= drv;
		o_mdio <= drv ? v : ~o_mdio; // released: old level never lingers
		repeat (4) @(negedge i_clk);
		s = i_mdio;
		o_mdc <= 1'b1;
		repeat (4) @(negedge i_clk);
		o_mdc <= 1'b0;
	endtask
	// fresh preamble every frame, turnaround released on reads
	task automatic xfer(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] rg,
		input logic [15:0] wd, output logic [15:0] rd);
		logic [45:0] hdr;
		logic s;
		hdr = {32'hFFFFFFFF, START_CODE, op, phy, rg};
		@(negedge i_clk);
		for (int i = 45; i >= 0; i--) begin
			bit_cyc(1'b1, hdr[i], s);
		end
		bit_cyc(op == OP_WRITE, 1'b1, s);
		bit_cyc(op == OP_WRITE, 1'b0, s);
		for (int i = 15; i >= 0; i--) begin
			bit_cyc(op == OP_WRITE, wd[i], s);
			rd[i] = s;
		end
		o_oe <= 1'b0;
		repeat (8) @(negedge i_clk);
	endtask
endmodule
`default_nettype wire

/* testbench/test_phyev_top.sv */
`timescale 1ns/10ps
`default_nettype none
module test_phyev_top;
	import phyev_pkg::*;
	localparam int EMAX = 8;
	logic clk = 1'b0, rst = 1'b1, fiber = 1'b0, an_en = 1'b1, an_done = 1'b0, lp = 1'b0, pp = 1'b0;
	logic link = 1'b1, spd = 1'b0, dup = 1'b0, pin_lvl = 1'b0, strap = 1'b1;
	logic [6:0] ev = 7'h00;
	logic mdc, h_mdio, h_oe, d_mdio, d_oe, irq_pin, irq_oe, pdn, mii, fef, fext, oob, anal, scr;
	logic [15:0] v, w;
	int failures = 0, checked = 0, seed;
	// pull-up on the data line; shared pin follows its driver
	wire logic mdio_w = d_oe ? d_mdio : (h_oe ? h_mdio : 1'b1);
	wire logic pin_w = irq_oe ? irq_pin : pin_lvl;
	always #20 clk = ~clk;
	phyev_top #(.PHY_ADDR(5'h01), .ERR_MAX(EMAX)) phyev_top_i (.I_CLK(clk), .I_RST(rst), .I_MDC(mdc),
		.I_MDIO(mdio_w), .O_MDIO(d_mdio), .O_MDIO_OE(d_oe), .I_PWRDN_IRQ_PIN(pin_w),
		.O_PWRDN_IRQ_PIN(irq_pin), .O_PWRDN_IRQ_OE(irq_oe), .O_POWER_DOWN(pdn), .I_MII_STRAP(strap),
		.I_FIBER_SEL(fiber), .I_AN_ENABLE(an_en), .I_AN_DONE(an_done), .I_LOCAL_PAUSE(lp),
		.I_PARTNER_PAUSE(pp), .I_LINK_UP(link), .I_SPEED_100(spd), .I_FULL_DUPLEX(dup),
		.I_REMOTE_FAULT(ev[5]), .I_ACK_MATCH(ev[3]), .I_PD_FAULT(ev[2]), .I_PAGE_RX(ev[1]),
		.I_RX_ERR(ev[0]), .O_MII_SEL(mii), .O_FEF_ACTIVE(fef), .O_FIFO_EXT(fext), .O_RMII_OOB(oob),
		.O_AN_ALLOWED(anal), .O_SCRAMBLE_EN(scr));
	phyev_mdio_host phyev_mdio_host_i (.i_clk(clk), .i_mdio(mdio_w), .o_mdc(mdc), .o_mdio(h_mdio), .o_oe(h_oe));
	task automatic tally_and_finish();
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic chk16(input string nm, input logic [15:0] e, input logic [15:0] g);
		checked++;
		if (g !== e) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chk1(input string nm, input logic e, input logic g);
		checked++;
		if (g !== e) begin
			failures++;
			$display("[ERR] %s expected %b seen %b", nm, e, g);
		end
	endtask
	task automatic rd(input logic [4:0] r, output logic [15:0] d);
		phyev_mdio_host_i.xfer(OP_READ, 5'h01, r, 16'h0000, d);
	endtask
	task automatic wr(input logic [4:0] r, input logic [15:0] d);
		logic [15:0] x;
		phyev_mdio_host_i.xfer(OP_WRITE, 5'h01, r, d, x);
	endtask
	// expected status word from the levels the bench drives
	function automatic logic [15:0] sts(input logic [6:0] fl);
		return {5'h00, fiber, spd, dup, an_done & lp & pp, fl};
	endfunction
	// edge events toggle their level, others pulse one cycle
	task automatic fire(input int k, input int cnt);
		for (int i = 0; i < cnt; i++) begin
			@(negedge clk);
			if (k == 6) an_done <= 1'b0;
			else if (k == 4) link <= 1'b0;
			else ev[k] <= 1'b1;
			@(negedge clk);
			if (k == 6) an_done <= 1'b1;
			else if (k == 4) link <= 1'b1;
			else ev[k] <= 1'b0;
		end
		repeat (3) @(negedge clk);
	endtask
	initial begin
		#2000000;
		failures++;
		tally_and_finish();
	end
	initial begin
		seed = $urandom(32'h39a4c5b7);
		repeat (2) @(negedge clk);
		rst <= 1'b0;
		repeat (3) @(negedge clk);
		rd(REG_MAC_IF_CFG, v);
		chk16("cfg_reset", CFG_RST | 16'h0200, v);
		rd(REG_EVT_ENABLE, v);
		chk16("ena_reset", ENA_RST, v);
		chk1("irq_oe_reset", 1'b0, irq_oe);
		chk1("power_down_low", 1'b0, pdn);
		// config writes: all ones, all zeros, then random
		for (int n = 0; n < 4; n++) begin
			w = (n == 0) ? 16'hFFFF : (n == 1) ? 16'h0000 : 16'($urandom);
			an_en <= w[15];
			wr(REG_MAC_IF_CFG, w);
			rd(REG_MAC_IF_CFG, v);
			chk16("cfg_rdbk", (w & CFG_WR_MASK) | CFG_RST, v);
			chk1("mii_sel", w[9], mii);
			chk1("fef", w[5] & ~an_en, fef);
			chk1("fifo_ext", w[2], fext);
			chk1("oob", w[1] & ~w[9], oob);
		end
		// link status levels; first read flushes any event
		for (int n = 0; n < 4; n++) begin
			w = (n == 0) ? 16'h0003 : 16'($urandom);
			{fiber, spd, dup, an_done, lp, pp} <= (n == 0) ? 6'h03 : w[5:0];
			rd(REG_EVT_STATUS, v);
			rd(REG_EVT_STATUS, v);
			chk16("sts_lvl", sts(7'h00), v);
			chk1("an_allowed", an_en & ~fiber, anal);
			chk1("scramble", ~fiber, scr);
		end
		for (int k = 0; k < NUM_EV; k++) begin
			fire(k, (k == 0) ? EMAX : 1);
			rd(REG_EVT_STATUS, v);
			chk16("evt_set", sts(7'(1 << k)), v);
			rd(REG_EVT_STATUS, v);
			chk16("evt_clr", sts(7'h00), v);
		end
		// error count short of the limit twice, cleared by each read
		for (int n = 0; n < 2; n++) begin
			fire(0, EMAX - 1);
			rd(REG_EVT_STATUS, v);
			chk16("err_clr", sts(7'h00), v);
		end
		wr(REG_EVT_ENABLE, 16'h0088);
		chk1("irq_oe", 1'b1, irq_oe);
		fire(2, 1);
		chk1("irq_masked", 1'b1, irq_pin);
		fire(3, 1);
		chk1("irq_on", 1'b0, irq_pin);
		wr(REG_EVT_ENABLE, 16'h007F);
		chk1("irq_global_off", 1'b1, irq_pin);
		wr(REG_EVT_ENABLE, 16'h00FF);
		chk1("irq_pending", 1'b0, irq_pin);
		rd(REG_EVT_STATUS, v);
		chk16("sts_pend", sts(7'h0C), v);
		chk1("irq_off", 1'b1, irq_pin);
		// refused accesses
		wr(REG_EVT_STATUS, 16'hFFFF);
		rd(REG_EVT_STATUS, v);
		chk16("sts_ro", sts(7'h00), v);
		rd(5'h05, v);
		chk16("unmapped", 16'h0000, v);
		phyev_mdio_host_i.xfer(OP_READ, 5'h1F, REG_MAC_IF_CFG, 16'h0000, v);
		chk16("wrong_phy", 16'hFFFF, v);
		wr(REG_EVT_ENABLE, 16'hFFFF);
		rd(REG_EVT_ENABLE, v);
		chk16("ena_rdbk", ENA_WR_MASK, v);
		pin_lvl <= 1'b1;
		repeat (6) @(negedge clk);
		chk1("power_down", 1'b1, pdn);
		// second reset in mid-run with the strap low picks the reduced interface
		strap <= 1'b0;
		rst <= 1'b1;
		repeat (2) @(negedge clk);
		rst <= 1'b0;
		repeat (3) @(negedge clk);
		chk1("mii_strap_low", 1'b0, mii);
		rd(REG_MAC_IF_CFG, v);
		chk16("cfg_strap_low", CFG_RST, v);
		tally_and_finish();
	end
endmodule
`default_nettype wire
